// ### verilog/cdkf_pkg.sv
// package: constants for the comparator delay kill filter
package cdkf_pkg;
    // apb register byte addresses
    localparam logic [11:0] CDKF_ADDR_CTRL = 12'h0A2 << 2;
    localparam logic [11:0] CDKF_ADDR_STATUS = 12'h300;
    localparam logic [11:0] CDKF_ADDR_IRQ_STAT = 12'h304;
    localparam logic [11:0] CDKF_ADDR_IRQ_MASK = 12'h308;
    localparam logic [11:0] CDKF_ADDR_CMP_CFG = 12'h30C;
    // control register fields
    localparam int CDKF_BIT_ENABLE = 7;
    localparam int CDKF_BIT_WAKESEL = 6;
    localparam int CDKF_BIT_FILTDIS = 5;
    localparam int CDKF_BIT_STYLE = 4;
    localparam int CDKF_DLY_MSB = 3;
    localparam int CDKF_DLY_W = 4;
    localparam logic [7:0] CDKF_CTRL_RESET = 8'h00;
    // status fields
    localparam int CDKF_ST_COUT = 0;
    localparam int CDKF_ST_KILL = 1;
    localparam int CDKF_ST_ARMED = 2;
    // interrupt events
    localparam int CDKF_EV_KILL = 0;
    localparam int CDKF_EV_RISE = 1;
    localparam int CDKF_EV_ABORT = 2;
    localparam int CDKF_EV_W = 3;
    // comparator configuration: loop select
    localparam int CDKF_CFG_LOOP = 0;
    localparam int CDKF_DATA_W = 8;
    // filter states
    typedef enum logic [1:0] {CDKF_IDLE, CDKF_COUNT, CDKF_SPENT} cdkf_state_type;
endpackage

// ### verilog/cdkf_delay_counter.sv
// delay counter advanced by reference clock two ticks
`timescale 1ns/1ns
`default_nettype none
module cdkf_delay_counter
    import cdkf_pkg::*;
#(
    parameter int WIDTH = CDKF_DLY_W
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic start,
    input wire logic run,
    input wire logic tick,
    input wire logic [WIDTH-1:0] target,
    output logic done
);
    logic [WIDTH-1:0] count;
    wire atTarget = (count == target);
    // ==========================================
    // counter
    // restart clears the count; done stays high each cycle the count is at the match while running
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= '0;
            done <= 1'b0;
        end
        else if (clkEn)
        begin
            done <= 1'b0;
            if (start)
                count <= '0;
            else if (run && tick && !atTarget)
                count <= count + 1'b1;
            else if (run && atTarget)
                done <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### verilog/cdkf_filter.sv
// top: comparator delay kill filter with apb registers
// Overview of operation
// - comparator high when input exceeds source
// - rising edge restarts counter, compared to select
// - count matched and still high raises kill
// - counter advances per reference clock two period
// - enable bit 7 low holds comparator low
// - bit 6 routes kill to wakeup channel
// - bit 5 high disables filter and kill
// - style 0 kill stops timer outputs
// - style 1 blanks outputs current cycle only
// - one kill per comparator rising edge
// - control register holds listed fields
// - comparator sampled into read-only status bit
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module cdkf_filter
    import cdkf_pkg::*;
#(
    parameter int DLY_W = CDKF_DLY_W
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog comparator raw results, asynchronous
    input wire logic aboveThreshold,
    input wire logic aboveAmp,
    // reference clock two, asynchronous level
    input wire logic referenceClockTwo,
    // port pin six, asynchronous
    input wire logic portPinSix,
    // pwm timer side
    input wire logic pwmModeActive,
    input wire logic pwmCycleEnd,
    output logic pwmKill,
    output logic timerStop,
    output logic outputBlank,
    output logic wakeChannelSix,
    output logic irq
);
    import cdkf_pkg::*;

    // ==========================================
    // registers and synchronisers
    // software-visible state
    logic [7:0] ctrl;
    logic [CDKF_EV_W-1:0] irqStat;
    logic [CDKF_EV_W-1:0] irqMask;
    logic loopSelect;
    // pin and reference clock pairs; stage one is read by nothing else
    logic [1:0] thrSync;
    logic [1:0] ampSync;
    logic [1:0] rclkSync;
    logic [1:0] pinSync;
    // comparator output and edge history
    logic cout;
    logic coutPrev;
    logic rclkPrev;
    logic coutLatched;
    // filter sequencing
    cdkf_state_type state;
    logic counterDone;

    // ==========================================
    // address match, shared by every register decode
    function automatic logic addrIs(
        input logic [11:0] addr,
        input logic [11:0] match
    );
        return addr == match;
    endfunction

    // ==========================================
    // decode
    // control fields
    wire compEnable = ctrl[CDKF_BIT_ENABLE];
    wire wakeSelect = ctrl[CDKF_BIT_WAKESEL];
    wire filterDisable = ctrl[CDKF_BIT_FILTDIS];
    wire shutdownStyle = ctrl[CDKF_BIT_STYLE];
    wire [DLY_W-1:0] delaySelect = ctrl[CDKF_DLY_MSB -: DLY_W];

    // comparator path; the enable gates after the input mux
    wire rawCompare = loopSelect ? ampSync[1] : thrSync[1];
    wire next_cout = compEnable & rawCompare;
    wire coutRise = cout & ~coutPrev;
    wire rclkTick = rclkSync[1] & ~rclkPrev;

    // filter control; disable also masks a kill already due
    wire filterOn = ~filterDisable;
    wire startCount = coutRise & filterOn;
    wire counting = (state == CDKF_COUNT);
    wire killFire = counting & counterDone & cout & filterOn;
    wire abortCount = counting & ~cout;

    // bus decode; writes land only on the edge that ends the access
    wire accessWait = psel & penable & ~pready;
    wire wrEn = psel & penable & pready & pwrite;
    wire rdEn = psel & ~penable & ~pwrite;
    wire hitCtrl = addrIs(paddr, CDKF_ADDR_CTRL);
    wire hitStat = addrIs(paddr, CDKF_ADDR_STATUS);
    wire hitIrqS = addrIs(paddr, CDKF_ADDR_IRQ_STAT);
    wire hitIrqM = addrIs(paddr, CDKF_ADDR_IRQ_MASK);
    wire hitCfg = addrIs(paddr, CDKF_ADDR_CMP_CFG);
    wire mapped = hitCtrl | hitStat | hitIrqS | hitIrqM | hitCfg;

    // events and their write-one-clear
    wire [CDKF_EV_W-1:0] events = {abortCount, startCount, killFire};
    wire [CDKF_EV_W-1:0] w1c = (wrEn & hitIrqS) ? pwdata[CDKF_EV_W-1:0] : '0;
    wire [CDKF_EV_W-1:0] next_irqStat = (irqStat & ~w1c) | events;

    // read mux; unmapped words read as zero beside the error
    wire [7:0] statusWord = {5'h00, counting, pwmKill, coutLatched};
    wire [31:0] next_prdata =
        hitCtrl ? {24'h000000, ctrl} :
        hitStat ? {24'h000000, statusWord} :
        hitIrqS ? {29'h00000000, irqStat} :
        hitIrqM ? {29'h00000000, irqMask} :
        hitCfg ? {31'h00000000, loopSelect} : 32'h00000000;

    // ==========================================
    // two-flop synchronisers for pins and the reference clock
    // the reference clock is slow enough to be sampled as a level
    // only the second stage of each pair feeds any logic
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            thrSync <= 2'h0;
            ampSync <= 2'h0;
            rclkSync <= 2'h0;
            pinSync <= 2'h0;
        end
        else if (clkEn)
        begin
            thrSync <= {thrSync[0], aboveThreshold};
            ampSync <= {ampSync[0], aboveAmp};
            rclkSync <= {rclkSync[0], referenceClockTwo};
            pinSync <= {pinSync[0], portPinSix};
        end
    end

    // ==========================================
    // comparator output and its edge history
    // coutPrev starts low like cout, so no false edge follows reset
    // the reference tick detector shares the same reset reasoning
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cout <= 1'b0;
            coutPrev <= 1'b0;
            rclkPrev <= 1'b0;
            coutLatched <= 1'b0;
        end
        else if (clkEn)
        begin
            cout <= next_cout;
            coutPrev <= cout;
            rclkPrev <= rclkSync[1];
            coutLatched <= cout;
        end
    end

    // ==========================================
    // filter state: spent waits for cout to drop, so one kill per edge
    // idle: wait for a rising edge of cout with the filter on
    // count: the counter runs on reference ticks up to the select
    // spent: kill has fired; a new one needs cout low then high
    // a zero select fires two cycles after the edge, with no tick
    // limitation: cout is sampled on ref_clk, so a glitch shorter
    // than one clock can be missed; the price of the synchroniser
    // turning the filter off mid-count drops back to idle at once
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            state <= CDKF_IDLE;
        else if (clkEn)
        begin
            case (state)
                CDKF_IDLE:
                    if (startCount)
                        state <= CDKF_COUNT;
                CDKF_COUNT:
                    if (filterDisable || abortCount)
                        state <= CDKF_IDLE;
                    else if (killFire)
                        state <= CDKF_SPENT;
                CDKF_SPENT:
                    if (!cout)
                        state <= CDKF_IDLE;
                default:
                    state <= CDKF_IDLE;
            endcase
        end
    end

    // ==========================================
    // delay counter
    // started only from idle, so a stray edge cannot restart a count
    cdkf_delay_counter #(
        .WIDTH(DLY_W)
    ) cdkf_delay_counter_i (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .start(startCount && state == CDKF_IDLE),
        .run(counting),
        .tick(rclkTick),
        .target(delaySelect),
        .done(counterDone)
    );

    // ==========================================
    // kill pulse and timer effects, one cycle each
    // the stop pulse is raised only in pwm mode; otherwise nothing runs
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pwmKill <= 1'b0;
            timerStop <= 1'b0;
        end
        else if (clkEn)
        begin
            pwmKill <= killFire;
            timerStop <= killFire & ~shutdownStyle & pwmModeActive;
        end
    end

    // ==========================================
    // blanking holds until the cycle end, even with cout still high
    // a kill in the ending cycle wins and blanks the next cycle instead
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            outputBlank <= 1'b0;
        else if (clkEn)
        begin
            if (killFire && shutdownStyle && pwmModeActive)
                outputBlank <= 1'b1;
            else if (pwmCycleEnd)
                outputBlank <= 1'b0;
        end
    end

    // ==========================================
    // wakeup routing
    // the pin path takes one register after its synchroniser, as the kill path does
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            wakeChannelSix <= 1'b0;
        else if (clkEn)
            wakeChannelSix <= wakeSelect ? killFire : pinSync[1];
    end

    // ==========================================
    // control register; only its low byte exists
    // upper data bits are dropped on write and read back as zero
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            ctrl <= CDKF_CTRL_RESET;
        else if (clkEn && wrEn && hitCtrl)
            ctrl <= pwdata[CDKF_DATA_W-1:0];
    end

    // ==========================================
    // interrupt mask and comparator loop select
    // loop select lives apart from the control byte, in its own word
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irqMask <= '0;
            loopSelect <= 1'b0;
        end
        else if (clkEn)
        begin
            if (wrEn && hitIrqM)
                irqMask <= pwdata[CDKF_EV_W-1:0];
            if (wrEn && hitCfg)
                loopSelect <= pwdata[CDKF_CFG_LOOP];
        end
    end

    // ==========================================
    // sticky events; a set in the clearing cycle wins
    // irq reads the next status, so it follows an event by one edge
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irqStat <= '0;
            irq <= 1'b0;
        end
        else if (clkEn)
        begin
            irqStat <= next_irqStat;
            irq <= |(next_irqStat & irqMask);
        end
    end

    // ==========================================
    // handshake: one wait state, ready and error pulse together
    // back-to-back transfers work: ready drops by itself after a cycle
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clkEn)
        begin
            pready <= accessWait;
            pslverr <= accessWait & ~mapped;
        end
    end

    // ==========================================
    // read data taken at setup and held until the next read
    // status is a snapshot of the setup cycle, not of the ready edge
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            prdata <= 32'h00000000;
        else if (clkEn && rdEn)
            prdata <= next_prdata;
    end
endmodule
`default_nettype wire

// ### tb/cdkf_monitor.sv
// checker on the ports of the comparator delay kill filter
`timescale 1ns/1ns
`default_nettype none
module cdkf_monitor (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic pwmModeActive,
    input wire logic pwmCycleEnd,
    input wire logic pwmKill,
    input wire logic timerStop,
    input wire logic outputBlank
);
    // ==========
    // properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    AST_KILL_ONCE: assert property (pwmKill |=> !pwmKill [*2])
        else $error("kill pulse too long");
    AST_STOP_FROM_KILL: assert property ($rose(timerStop) |-> pwmKill || $past(pwmKill))
        else $error("stop without kill");
    AST_STOP_IN_MODE: assert property (timerStop |-> pwmModeActive || $past(pwmModeActive))
        else $error("stop outside pwm mode");
    AST_BLANK_FROM_KILL: assert property ($rose(outputBlank) |-> pwmKill || $past(pwmKill))
        else $error("blank without kill");
    AST_BLANK_HOLD: assert property (outputBlank && !pwmCycleEnd |=> outputBlank)
        else $error("blank dropped early");
    AST_BLANK_END: assert property (outputBlank && pwmCycleEnd && !pwmKill |=> ##[0:1] !outputBlank)
        else $error("blank held past cycle end");
    AST_APB_ANSWER: assert property (psel && penable && !pready && clkEn |-> ##[1:3] pready)
        else $error("no apb answer");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready too long");
    AST_SLVERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // main scenarios reached
    cover property (pwmKill && pwmModeActive);
    cover property (timerStop);
    cover property (outputBlank && pwmCycleEnd);
endmodule
bind cdkf_filter cdkf_monitor cdkf_monitor_i (.ref_clk, .resetn, .clkEn,
    .psel, .penable, .pready, .pslverr, .pwmModeActive, .pwmCycleEnd,
    .pwmKill, .timerStop, .outputBlank);
`default_nettype wire

// ### tb/cdkf_pwm_model.sv
// stand-in for the pwm timer and the wakeup channel six edge logic
`timescale 1ns/1ns
`default_nettype none
module cdkf_pwm_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic timerStop,
    input wire logic wakeChannelSix,
    input wire logic rerun,
    input wire logic clrWake,
    output logic pwmModeActive,
    output logic pwmCycleEnd,
    output logic wakePending
);
    logic [5:0] phase;
    logic wakeLast;
    // ==========
    // 64-cycle pwm period, run bit, rising-edge wake flag
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            phase <= 6'h00;
            pwmCycleEnd <= 1'b0;
            pwmModeActive <= 1'b0;
            wakeLast <= 1'b0;
            wakePending <= 1'b0;
        end
        else
        begin
            phase <= phase + 6'h01;
            pwmCycleEnd <= (phase == 6'h3F);
            if (timerStop)
                pwmModeActive <= 1'b0;
            else if (rerun)
                pwmModeActive <= 1'b1;
            wakeLast <= wakeChannelSix;
            // edge select cleared: only rising edges set the flag
            if (clrWake)
                wakePending <= 1'b0;
            else if (wakeChannelSix && !wakeLast)
                wakePending <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### tb/cdkf_filter_tb.sv
// self-checking bench for the comparator delay kill filter
`timescale 1ns/1ns
`default_nettype none
module cdkf_filter_tb;
    import cdkf_pkg::*;
    logic ref_clk, resetn, clkEn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic aboveThreshold, aboveAmp, refClk2, portPinSix, pwmModeActive;
    logic pwmCycleEnd, pwmKill, timerStop, outputBlank, wakeChannelSix;
    logic irq, rerun, clrWake, wakePending, e;
    int n_errors = 0, n_compared = 0, kills = 0, stops = 0, c;
    cdkf_filter cdkf_filter_i (.ref_clk, .resetn, .clkEn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .aboveThreshold,
        .aboveAmp, .referenceClockTwo(refClk2), .portPinSix, .pwmModeActive,
        .pwmCycleEnd, .pwmKill, .timerStop, .outputBlank, .wakeChannelSix,
        .irq);
    cdkf_pwm_model cdkf_pwm_model_i (.ref_clk, .resetn, .timerStop,
        .wakeChannelSix, .rerun, .clrWake, .pwmModeActive, .pwmCycleEnd,
        .wakePending);
    // ==========
    // clocks, event counters, watchdog
    initial
    begin
        ref_clk = 0;
        forever #25 ref_clk = ~ref_clk;
    end
    // reference clock two: 8 ref_clk periods
    always @(posedge ref_clk)
    begin
        if (pwmKill === 1'b1) kills++;
        if (timerStop === 1'b1) stops++;
    end
    initial
    begin
        refClk2 = 0;
        forever
        begin
            repeat (4) @(posedge ref_clk);
            refClk2 <= ~refClk2;
        end
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        end_of_test();
    end
    // ==========
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 50);
        chk("apb ready", 1, pready);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // raise one comparator input, count cycles to the kill pulse
    task automatic rise(input logic amp);
        c = 0;
        if (amp) aboveAmp <= 1'b1;
        else aboveThreshold <= 1'b1;
        while (pwmKill !== 1'b1 && c < 300) begin @(posedge ref_clk); c++; end
        chk("kill seen", 1, pwmKill);
    endtask
    task automatic fall;
        {aboveThreshold, aboveAmp} <= 2'b00;
        idle(12);
    endtask
    task automatic end_of_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_regs;
        apb(0, CDKF_ADDR_CTRL, 0); chk("ctrl reset", 32'h00, r);
        apb(1, CDKF_ADDR_CTRL, 32'hFFFF_FF5A); apb(0, CDKF_ADDR_CTRL, 0);
        chk("ctrl rw", 32'h5A, r);
        apb(0, 12'h0FC, 0); chk("unmapped err", 1, e);
        apb(1, CDKF_ADDR_CTRL, 32'h02); apb(1, CDKF_ADDR_STATUS, 32'h01);
        apb(0, CDKF_ADDR_STATUS, 0); chk("status ro", 0, r[0]);
        $display("test regs done");
    endtask
    task automatic t_kill;
        rerun <= 1; portPinSix <= 1; clkEn <= 0; idle(8);
        chk("frozen wake", 0, wakeChannelSix);
        clkEn <= 1; idle(8); chk("pin wake", 1, wakePending);
        {rerun, clrWake, portPinSix} <= 3'b010; idle(1); clrWake <= 0;
        apb(1, CDKF_ADDR_CTRL, 32'h82); rise(0);
        chk("delay2 window", 1, c >= 8 && c <= 40);
        idle(3); chk("stopped", 0, pwmModeActive); chk("stop", 1, stops);
        apb(0, CDKF_ADDR_STATUS, 0); chk("cout bit", 1, r[0]);
        idle(200); chk("one kill", 1, kills); fall();
        rerun <= 1; apb(1, CDKF_ADDR_CTRL, 32'hCF); rerun <= 0; rise(0);
        chk("delay15 window", 1, c >= 112 && c <= 144); idle(3);
        chk("kill wake", 1, wakePending); fall();
        apb(1, CDKF_ADDR_CTRL, 32'h8F); aboveThreshold <= 1; idle(60); fall();
        idle(200); chk("abort", 2, kills);
        $display("test kill done");
    endtask
    task automatic t_off;
        apb(1, CDKF_ADDR_CTRL, 32'h20);
        apb(1, CDKF_ADDR_CTRL, 32'hA0); aboveThreshold <= 1; idle(100);
        chk("filter off", 2, kills); fall();
        apb(1, CDKF_ADDR_CTRL, 32'h00); aboveThreshold <= 1; idle(100);
        apb(0, CDKF_ADDR_STATUS, 0); chk("cmp off cout", 0, r[0]);
        chk("cmp off", 2, kills); fall();
        $display("test off done");
    endtask
    task automatic t_blank;
        rerun <= 1; apb(1, CDKF_ADDR_IRQ_STAT, 32'h7); rerun <= 0;
        apb(1, CDKF_ADDR_IRQ_MASK, 32'h1); apb(1, CDKF_ADDR_CTRL, 32'h90);
        rise(0); chk("blank", 1, outputBlank); chk("irq", 1, irq);
        apb(0, CDKF_ADDR_IRQ_STAT, 0); chk("irq stat", 32'h3, r);
        chk("run kept", 1, pwmModeActive); c = 0;
        while (pwmCycleEnd !== 1'b1 && c < 100) begin @(posedge ref_clk); c++; end
        idle(3); chk("blank end", 0, outputBlank); fall();
        apb(1, CDKF_ADDR_IRQ_STAT, 32'h7); idle(2); chk("irq clr", 0, irq);
        apb(1, CDKF_ADDR_IRQ_MASK, 32'h0); apb(1, CDKF_ADDR_CMP_CFG, 32'h1);
        aboveThreshold <= 1; idle(100); chk("loop thr", 3, kills);
        rise(1); idle(3); chk("loop amp", 4, kills); chk("masked", 0, irq);
        fall(); $display("test blank done");
    endtask
    // ==========
    // main sequence
    initial
    begin
        {resetn, clkEn, psel, penable, pwrite, paddr, pwdata} = 0;
        {aboveThreshold, aboveAmp, portPinSix, rerun, clrWake} = 0;
        clkEn = 1;
        idle(2);
        resetn <= 1;
        t_regs();
        t_kill();
        t_off();
        t_blank();
        end_of_test();
    end
endmodule
`default_nettype wire
